// file: rtl/rst_seq_defines.svh
`ifndef RST_SEQ_DEFINES_SVH
`define RST_SEQ_DEFINES_SVH

// register byte offsets
`define RS_OFF_CAUSE 12'h000
`define RS_OFF_CONFIG 12'h004
`define RS_OFF_STATUS 12'h008

// cause register bit positions
`define RS_CAUSE_POWER 0
`define RS_CAUSE_PIN 1
`define RS_CAUSE_WATCHDOG 2
`define RS_CAUSE_BAD_OPCODE 3
`define RS_CAUSE_BAD_ADDRESS 4
`define RS_CAUSE_BROWNOUT 5
`define RS_CAUSE_W 6
`define RS_CAUSE_RESET 6'h01

// config register bit positions
`define RS_CFG_WATCHDOG_DISABLE 0
`define RS_CFG_SHORT_WAKE 1
`define RS_CFG_BO_POWER_DISABLE 2
`define RS_CFG_BO_RESET_DISABLE 3
`define RS_CFG_STOP_ENABLE 4
`define RS_CFG_W 5
`define RS_CFG_RESET 5'h00

// status register field positions
`define RS_STAT_STATE_LSB 0
`define RS_STAT_FROM_POWER 8
`define RS_STAT_INT_VALID 9
`define RS_STAT_VECTOR_LSB 10
`define RS_STAT_COUNT_LSB 16

// timing counts in oscillator cycles
`define RS_STAB_BITS 12
`define RS_STAB_LAST 12'hFFF
`define RS_SHORT_WAKE_LAST 12'h01F
`define RS_DRIVE_CYCLES 32
`define RS_EXTEND_CYCLES 32
`define RS_PIN_MIN_CYCLES 67
`define RS_PIN_POWER_CYCLES 4163
`define RS_PIN_CNT_BITS 13

`endif

// file: rtl/rst_seq_pkg.sv
`default_nettype none
package rst_seq_pkg;

   // one-hot sequencer states
   typedef enum logic [6:0] {
      ST_STAB = 7'b0000001,
      ST_DRIVE = 7'b0000010,
      ST_EXTEND = 7'b0000100,
      ST_PIN_HOLD = 7'b0001000,
      ST_RUN = 7'b0010000,
      ST_STOP = 7'b0100000,
      ST_WAKE = 7'b1000000
   } seq_state_t;

   // reset cause flags, msb first
   typedef struct packed {
      logic brownout_flag;
      logic bad_address_flag;
      logic bad_opcode_flag;
      logic watchdog_flag;
      logic pin_flag;
      logic power_flag;
   } cause_t;

   // configuration bits, msb first
   typedef struct packed {
      logic stop_enable;
      logic brownout_reset_disable;
      logic brownout_power_disable;
      logic short_wake_select;
      logic watchdog_disable;
   } config_t;

   // processor-side event strobes
   typedef struct packed {
      logic bad_opcode;
      logic stop_exec;
      logic opcode_fetch;
      logic unmapped_access;
      logic wake_event;
   } cpu_events_t;

endpackage
`default_nettype wire

// file: rtl/stab_counter.sv
`timescale 1ns/1ns
`default_nettype none

module stab_counter
#(
   parameter int WIDTH = 12
)
(
   input wire logic hclk, // oscillator clock
   input wire logic hresetn, // async reset, active low
   input wire logic clear, // hold counter at zero
   output logic [WIDTH-1:0] count, // current count
   output logic overflow // one-cycle pulse on wrap
);

   // advances on the falling edge so the rising-edge sequencer sees a settled value
   always_ff @(negedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         count <= '0;
      else if (clear)
         count <= '0;
      else
         count <= count + 1'b1;
   end

   // wrap pulse doubles as the watchdog prescaler output
   always_ff @(negedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         overflow <= 1'b0;
      else
         overflow <= !clear && (&count);
   end

endmodule

`default_nettype wire

// file: rtl/int_latch.sv
`timescale 1ns/1ns
`default_nettype none

module int_latch
#(
   parameter int NUM = 8,
   parameter int IDX_W = 3
)
(
   input wire logic hclk, // clock
   input wire logic hresetn, // async reset, active low
   input wire logic sync_clear, // internal reset flushes the latch
   input wire logic [NUM-1:0] int_req, // requests, bit 0 highest priority
   input wire logic int_mask, // processor interrupt mask
   input wire logic int_service, // latched interrupt has been serviced
   output logic int_valid, // an interrupt is latched
   output logic [IDX_W-1:0] int_vector // latched vector selector
);

   logic mask_d;

   // lowest index wins
   function automatic logic [IDX_W-1:0] pick(input logic [NUM-1:0] req);
      pick = '0;
      for (int i = NUM - 1; i >= 0; i--)
         if (req[i])
            pick = IDX_W'(i);
   endfunction

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         mask_d <= 1'b1;
      else
         mask_d <= int_mask;
   end

   // once latched the selector stays constant; a later higher priority request waits
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         int_valid <= 1'b0;
         int_vector <= '0;
      end
      else if (sync_clear)
      begin
         int_valid <= 1'b0;
         int_vector <= '0;
      end
      else if (int_valid)
      begin
         if (int_service || (mask_d && !int_mask))
            int_valid <= 1'b0;
      end
      else if (!int_mask && (|int_req))
      begin
         int_valid <= 1'b1;
         int_vector <= pick(int_req);
      end
   end

endmodule

`default_nettype wire

// file: rtl/reset_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
`include "rst_seq_defines.svh"

module reset_sequencer
#(
   parameter int NUM_INT = 8,
   parameter int INT_IDX_W = 3,
   parameter int PIN_POWER_CYCLES = `RS_PIN_POWER_CYCLES
)
(
   input wire logic hclk, // oscillator clock, 20 MHz
   input wire logic hresetn, // async reset, active low
   input wire logic hsel, // ahb slave select
   input wire logic [11:0] haddr, // ahb byte address
   input wire logic [1:0] htrans, // ahb transfer type
   input wire logic hwrite, // ahb write
   input wire logic [2:0] hsize, // ahb size, word only
   input wire logic [31:0] hwdata, // ahb write data
   input wire logic hready, // ahb bus ready
   output logic [31:0] hrdata, // ahb read data
   output logic hreadyout, // ahb slave ready
   output logic hresp, // ahb response, always okay
   input wire logic rst_pin_in, // reset pin level
   output logic rst_pin_out, // reset pin drive level
   output logic rst_pin_oe_n, // reset pin enable, low drives
   input wire logic power_up_pulse, // power detector pulse
   input wire logic brownout_detect, // brownout detector output
   input wire logic watchdog_overflow, // watchdog overflow, asynchronous
   input wire rst_seq_pkg::cpu_events_t cpu_events, // processor event strobes
   input wire logic [NUM_INT-1:0] int_req, // interrupt requests
   input wire logic int_mask, // processor interrupt mask
   input wire logic int_service, // latched interrupt serviced
   output logic internal_reset, // internal reset, active high
   output logic bus_source_clock, // source clock enable
   output logic internal_bus_clocks, // processor and module clock enable
   output logic watchdog_tick, // watchdog prescaler clock
   output logic int_valid, // interrupt latched
   output logic [INT_IDX_W-1:0] int_vector // vector selector
);

   import rst_seq_pkg::*;
   typedef logic [`RS_PIN_CNT_BITS-1:0] pin_cnt_t;

   seq_state_t state;
   seq_state_t next_state;
   cause_t cause;
   config_t cfg;
   logic [5:0] seq_cnt;
   logic from_power;
   logic cnt_clear;
   logic next_cnt_clear;
   logic [`RS_STAB_BITS-1:0] stab_count;
   logic pin_s1;
   logic pin_s2;
   logic wd_s1;
   logic wd_s2;
   pin_cnt_t pin_low_cnt;
   logic ph_active;
   logic ph_write;
   logic [11:0] ph_addr;
   logic running;
   logic pin_low;
   logic wd_rst;
   logic op_rst;
   logic ad_rst;
   logic bo_rst;
   logic int_rst;
   logic stab_done;
   logic wake_done;
   logic pin_met;

   // register map decode shared by read and write paths
   function automatic logic is_reg(input logic [11:0] a, input logic [11:0] off);
      is_reg = (a[11:2] == off[11:2]);
   endfunction

   // ------------------------------------------------------------------
   // synchronisers: first stage is read only by the second
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pin_s1 <= 1'b1;
         pin_s2 <= 1'b1;
      end
      else
      begin
         pin_s1 <= rst_pin_in;
         pin_s2 <= pin_s1;
      end
   end

   // watchdog overflow can arrive on any phase, so it is resynchronised
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wd_s1 <= 1'b0;
         wd_s2 <= 1'b0;
      end
      else
      begin
         wd_s1 <= watchdog_overflow;
         wd_s2 <= wd_s1;
      end
   end

   // ------------------------------------------------------------------
   // reset source qualification
   assign running = (state == ST_RUN) || (state == ST_STOP) || (state == ST_WAKE);
   assign pin_low = !pin_s2;
   assign wd_rst = wd_s2 && !cfg.watchdog_disable;
   assign op_rst = cpu_events.bad_opcode || (cpu_events.stop_exec && !cfg.stop_enable);
   // a data access never qualifies, only an opcode fetch does
   assign ad_rst = cpu_events.unmapped_access && cpu_events.opcode_fetch;
   assign bo_rst = brownout_detect && !cfg.brownout_power_disable && !cfg.brownout_reset_disable;
   assign int_rst = running && (wd_rst || op_rst || ad_rst);
   // counter value is trusted only one edge after a clear request drops
   assign stab_done = !cnt_clear && (stab_count == `RS_STAB_LAST) && !brownout_detect;
   assign wake_done = !cnt_clear && (stab_count == (cfg.short_wake_select ? `RS_SHORT_WAKE_LAST
                                                                          : `RS_STAB_LAST));
   assign pin_met = pin_low && (pin_low_cnt == (from_power ? pin_cnt_t'(PIN_POWER_CYCLES - 1)
                                                           : pin_cnt_t'(`RS_PIN_MIN_CYCLES - 1)));

   // ------------------------------------------------------------------
   // sequencer next state and counter clear request
   always_comb
   begin
      next_state = state;
      next_cnt_clear = 1'b0;
      if (power_up_pulse || (bo_rst && state != ST_STAB))
      begin
         next_state = ST_STAB;
         next_cnt_clear = 1'b1;
      end
      else if (int_rst)
      begin
         next_state = ST_DRIVE;
         next_cnt_clear = 1'b1;
      end
      else if (running && pin_low)
         next_state = ST_PIN_HOLD;
      else
      begin
         unique case (state)
            ST_STAB:
            begin
               // detector still asserted keeps the wait restarting
               next_cnt_clear = brownout_detect;
               if (stab_done)
                  next_state = ST_DRIVE;
            end
            ST_DRIVE:
               if (seq_cnt == 6'(`RS_DRIVE_CYCLES - 1))
                  next_state = ST_EXTEND;
            ST_EXTEND:
               if (seq_cnt == 6'(`RS_EXTEND_CYCLES - 1))
                  next_state = ST_RUN;
            ST_PIN_HOLD:
               if (!pin_low)
                  next_state = ST_EXTEND;
            ST_RUN:
               if (cpu_events.stop_exec && cfg.stop_enable)
               begin
                  next_state = ST_STOP;
                  next_cnt_clear = 1'b1;
               end
            ST_STOP:
            begin
               // held clear until recovery begins
               next_cnt_clear = !cpu_events.wake_event;
               if (cpu_events.wake_event)
                  next_state = ST_WAKE;
            end
            ST_WAKE:
               if (wake_done)
                  next_state = ST_RUN;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state <= ST_STAB;
         cnt_clear <= 1'b1;
      end
      else
      begin
         state <= next_state;
         cnt_clear <= next_cnt_clear;
      end
   end

   // phase counter for the drive and extension windows
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         seq_cnt <= '0;
      else if (next_state != state)
         seq_cnt <= '0;
      else
         seq_cnt <= seq_cnt + 1'b1;
   end

   // remembers a power or brownout origin until the sequence completes
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         from_power <= 1'b1;
      else if (next_state == ST_STAB)
         from_power <= 1'b1;
      else if (next_state == ST_RUN)
         from_power <= 1'b0;
   end

   // low time of the synchronised pin, saturating
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         pin_low_cnt <= '0;
      else if (!pin_low)
         pin_low_cnt <= '0;
      else if (!(&pin_low_cnt))
         pin_low_cnt <= pin_low_cnt + 1'b1;
   end

   // ------------------------------------------------------------------
   // cause flags; a new source replaces the old set, the pin flag adds on
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         cause <= cause_t'(`RS_CAUSE_RESET);
      else if (power_up_pulse)
         cause <= cause_t'(`RS_CAUSE_RESET);
      else if (bo_rst && state != ST_STAB)
      begin
         cause <= '0;
         cause.brownout_flag <= 1'b1;
      end
      else if (int_rst)
      begin
         cause <= '0;
         cause.watchdog_flag <= wd_rst;
         cause.bad_opcode_flag <= op_rst;
         cause.bad_address_flag <= ad_rst;
      end
      else if (pin_met)
         cause.pin_flag <= 1'b1;
   end

   // ------------------------------------------------------------------
   // pin drive, internal reset and clock gating all follow the next state
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rst_pin_out <= 1'b0;
         rst_pin_oe_n <= 1'b0;
         internal_reset <= 1'b1;
         bus_source_clock <= 1'b1;
         internal_bus_clocks <= 1'b0;
      end
      else
      begin
         rst_pin_out <= 1'b0;
         rst_pin_oe_n <= !(next_state == ST_STAB || next_state == ST_DRIVE);
         internal_reset <= !(next_state == ST_RUN || next_state == ST_STOP
                             || next_state == ST_WAKE);
         bus_source_clock <= (next_state != ST_STOP);
         internal_bus_clocks <= !(next_state == ST_STAB || next_state == ST_STOP
                                  || next_state == ST_WAKE);
      end
   end

   stab_counter #(
      .WIDTH(`RS_STAB_BITS)
   ) u_stab_counter (
      .hclk(hclk),
      .hresetn(hresetn),
      .clear(cnt_clear),
      .count(stab_count),
      .overflow(watchdog_tick)
   );

   int_latch #(
      .NUM(NUM_INT),
      .IDX_W(INT_IDX_W)
   ) u_int_latch (
      .hclk(hclk),
      .hresetn(hresetn),
      .sync_clear(internal_reset),
      .int_req(int_req),
      .int_mask(int_mask),
      .int_service(int_service),
      .int_valid(int_valid),
      .int_vector(int_vector)
   );

   // ------------------------------------------------------------------
   // ahb-lite slave: zero wait states, okay for every access
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // address phase capture for the write data phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ph_active <= 1'b0;
         ph_write <= 1'b0;
         ph_addr <= '0;
      end
      else if (hready)
      begin
         ph_active <= hsel && htrans[1];
         ph_write <= hwrite;
         ph_addr <= haddr;
      end
   end

   // configuration survives internal resets so recovery honours it
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         cfg <= config_t'(`RS_CFG_RESET);
      else if (ph_active && ph_write && is_reg(ph_addr, `RS_OFF_CONFIG))
         cfg <= config_t'(hwdata[`RS_CFG_W-1:0]);
   end

   // read data is fetched at the address phase so it stands for the data phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= '0;
      else if (hready && hsel && htrans[1] && !hwrite)
      begin
         hrdata <= '0;
         if (is_reg(haddr, `RS_OFF_CAUSE))
            hrdata[`RS_CAUSE_W-1:0] <= cause;
         else if (is_reg(haddr, `RS_OFF_CONFIG))
            hrdata[`RS_CFG_W-1:0] <= cfg;
         else if (is_reg(haddr, `RS_OFF_STATUS))
         begin
            hrdata[`RS_STAT_STATE_LSB +: 7] <= state;
            hrdata[`RS_STAT_FROM_POWER] <= from_power;
            hrdata[`RS_STAT_INT_VALID] <= int_valid;
            hrdata[`RS_STAT_VECTOR_LSB +: INT_IDX_W] <= int_vector;
            hrdata[`RS_STAT_COUNT_LSB +: `RS_STAB_BITS] <= stab_count;
         end
      end
   end

endmodule

`default_nettype wire

// file: verification/reset_sequencer_props.sv
`timescale 1ns/1ns
`default_nettype none

module reset_sequencer_props
#(
   parameter int NUM_INT = 8,
   parameter int INT_IDX_W = 3
)
(
   input wire logic hclk, // clock
   input wire logic hresetn, // reset, active low
   input wire logic rst_pin_in, // wire level
   input wire logic rst_pin_out, // drive level
   input wire logic rst_pin_oe_n, // drive enable
   input wire logic power_up_pulse, // power detector
   input wire logic brownout_detect, // brownout detector
   input wire logic watchdog_overflow, // watchdog request
   input wire rst_seq_pkg::cpu_events_t cpu_events, // strobes
   input wire logic [NUM_INT-1:0] int_req, // requests
   input wire logic int_mask, // mask
   input wire logic int_service, // serviced
   input wire logic internal_reset, // internal reset
   input wire logic bus_source_clock, // source clock
   input wire logic internal_bus_clocks, // cpu clocks
   input wire logic watchdog_tick, // prescaler tick
   input wire logic int_valid, // latched
   input wire logic [INT_IDX_W-1:0] int_vector // selector
);
   logic [12:0] lo_cnt;
   logic [12:0] hi_cnt;
   logic [12:0] w_cnt;
   logic drove;
   logic woke;
   logic running;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   assign running = internal_bus_clocks && !internal_reset;

   // run lengths of the drive and of the extension that follows it
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         lo_cnt <= 13'h0;
         hi_cnt <= 13'h0;
         drove <= 1'h0;
      end
      else
      begin
         lo_cnt <= !rst_pin_oe_n ? lo_cnt + 13'h1 : 13'h0;
         hi_cnt <= (internal_reset && rst_pin_oe_n) ? hi_cnt + 13'h1 : 13'h0;
         drove <= internal_reset && (drove || !rst_pin_oe_n); // pin resets never set this
      end
   end

   // cycles since a wake from stop, so the recovery delay can be judged
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         woke <= 1'h0;
         w_cnt <= 13'h0;
      end
      else if (cpu_events.wake_event && !bus_source_clock)
      begin
         woke <= 1'h1;
         w_cnt <= 13'h0;
      end
      else
      begin
         woke <= woke && !internal_bus_clocks && !internal_reset;
         w_cnt <= w_cnt + 13'h1;
      end
   end

   AST_DRIVE_LEN: assert property ($rose(rst_pin_oe_n) |-> (lo_cnt == 13'h20 || lo_cnt >= 13'h1004))
      else $error("reset wire drive length wrong");
   AST_EXTEND_LEN: assert property ($fell(internal_reset) && drove |-> hi_cnt == 13'h20)
      else $error("internal reset extension length wrong");
   AST_DRIVE_IN_RESET: assert property (!rst_pin_oe_n |-> internal_reset && !rst_pin_out)
      else $error("wire driven outside internal reset");
   AST_BAD_OPCODE: assert property (running && cpu_events.bad_opcode |-> ##[1:3] (internal_reset && !rst_pin_oe_n))
      else $error("bad opcode gave no reset");
   AST_BAD_FETCH: assert property (running && cpu_events.opcode_fetch && cpu_events.unmapped_access |-> ##[1:3] internal_reset)
      else $error("unmapped fetch gave no reset");
   AST_DATA_ACCESS: assert property (running && cpu_events == 5'h02 && !watchdog_overflow && rst_pin_in
      && !brownout_detect && !power_up_pulse |=> !internal_reset)
      else $error("data access caused a reset");
   AST_TICK_PULSE: assert property (watchdog_tick |=> !watchdog_tick [*8])
      else $error("prescaler tick too long");
   AST_INT_LATCH: assert property (!int_valid && !int_mask && int_req != '0 && !internal_reset |=> int_valid)
      else $error("request not latched");
   AST_INT_HOLD: assert property (int_valid && !int_service && !internal_reset && int_mask == $past(int_mask)
      && int_mask == $past(int_mask, 2) |=> int_valid && $stable(int_vector))
      else $error("latched interrupt lost precedence");
   AST_WAKE_DELAY: assert property ($rose(internal_bus_clocks) && woke |->
      ((w_cnt >= 13'h1E && w_cnt <= 13'h23) || (w_cnt >= 13'hFFE && w_cnt <= 13'h1003)))
      else $error("stop recovery delay wrong");
endmodule

bind reset_sequencer reset_sequencer_props #(.NUM_INT(NUM_INT), .INT_IDX_W(INT_IDX_W)) props_u (.hclk, .hresetn,
   .rst_pin_in, .rst_pin_out, .rst_pin_oe_n, .power_up_pulse, .brownout_detect, .watchdog_overflow, .cpu_events,
   .int_req, .int_mask, .int_service, .internal_reset, .bus_source_clock, .internal_bus_clocks, .watchdog_tick,
   .int_valid, .int_vector);

`default_nettype wire

// file: verification/reset_line_peer.sv
`timescale 1ns/1ns
`default_nettype none

module reset_line_peer
(
   input wire logic hclk, // clock
   input wire logic rst_pin_out, // device drive level
   input wire logic rst_pin_oe_n, // device enable, low drives
   input wire logic pull_req, // peer pulls the wire low
   output logic rst_wire, // resolved wire level
   output logic [15:0] low_len // last low run seen
);
   logic [15:0] run_len = 16'h0;

   // open drain with pull-up: whoever pulls wins, released wire goes high
   assign rst_wire = !((!rst_pin_oe_n && !rst_pin_out) || pull_req);

   // peripherals see the device drive as their own reset length
   always @(posedge hclk)
   begin
      run_len <= rst_wire ? 16'h0 : run_len + 16'h1;
      if (rst_wire && run_len != 16'h0)
         low_len <= run_len;
   end
endmodule

`default_nettype wire

// file: verification/tb_reset_sequencer_sim_counter.sv
`timescale 1ns/1ns
`default_nettype none
`include "rst_seq_defines.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end

module tb_reset_sequencer_sim_counter;
   import rst_seq_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, pull_req, rst_wire, rst_pin_out, rst_pin_oe_n;
   logic [11:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize, int_vector;
   logic [31:0] hwdata, hrdata, rd, ex, seed;
   logic power_up_pulse, brownout_detect, watchdog_overflow, int_mask, int_service;
   logic internal_reset, bus_source_clock, internal_bus_clocks, watchdog_tick, int_valid;
   logic [7:0] int_req;
   logic [15:0] low_len;
   cpu_events_t cpu_events;
   cpu_events_t ev_tab [4] = '{5'h10, 5'h08, 5'h06, 5'h02};
   int err_total = 0;
   int n, comparisons = 0;

   reset_sequencer dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .rst_pin_in(rst_wire), .rst_pin_out,
      .rst_pin_oe_n, .power_up_pulse, .brownout_detect, .watchdog_overflow, .cpu_events, .int_req, .int_mask,
      .int_service, .internal_reset, .bus_source_clock, .internal_bus_clocks, .watchdog_tick, .int_valid,
      .int_vector);
   reset_line_peer peer_u (.hclk, .rst_pin_out, .rst_pin_oe_n, .pull_req, .rst_wire, .low_len);

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // lowest set request wins
   function automatic logic [2:0] first_set(input logic [7:0] r);
      first_set = 3'h0;
      for (int i = 7; i >= 0; i--)
         if (r[i])
            first_set = i[2:0];
   endfunction

   function automatic logic [31:0] exp_cause(input cpu_events_t e, input logic [31:0] prev);
      if (e.bad_opcode || e.stop_exec)
         return 32'h08;
      if (e.opcode_fetch && e.unmapped_access)
         return 32'h10;
      return prev;
   endfunction

   // one ahb-lite single word transfer, waits on the slave ready
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rdv);
      hsel <= 1'h1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      rdv = hrdata;
   endtask

   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      bus(1'h0, a, 32'h0, rd);
      `CHK({hresp, rd}, {1'h0, e})
   endtask

   task automatic ev(input cpu_events_t e);
      cpu_events <= e;
      @(posedge hclk);
      cpu_events <= 5'h00;
      @(posedge hclk);
   endtask

   // bounded wait for the reset sequence to finish
   task automatic wait_run();
      n = 0;
      repeat (3) @(posedge hclk);
      while (internal_reset !== 1'h0 && n < 9000)
      begin
         @(posedge hclk);
         n++;
      end
      `CHK(internal_reset, 1'h0)
      repeat (2) @(posedge hclk);
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial
   begin
      hclk = 1'h0;
      forever #25 hclk = ~hclk;
   end

   // guard against a hang; the planned run is under 20000 cycles
   initial
   begin
      repeat (40000) @(posedge hclk);
      err_total++;
      give_verdict();
   end

   initial
   begin
      {hresetn, hsel, hwrite, pull_req, power_up_pulse, brownout_detect, watchdog_overflow} = 7'h00;
      {int_mask, int_service, haddr, htrans, hwdata, int_req, cpu_events} = '0;
      hsize = 3'h2;
      seed = 32'h4B67A851;
      repeat (5) @(posedge hclk);
      hresetn <= 1'h1;
      @(posedge hclk);
      `CHK({internal_reset, bus_source_clock, internal_bus_clocks}, 3'h6)
      wait_run();
      `CHK(n >= 4150, 1'h1)
      rchk(`RS_OFF_CAUSE, 32'h01);
      rchk(12'h00C, 32'h0);
      seed = lfsr(seed);
      bus(1'h1, `RS_OFF_CONFIG, seed, rd);
      rchk(`RS_OFF_CONFIG, {27'h0, seed[4:0]});
      bus(1'h1, `RS_OFF_CAUSE, 32'hFFFFFFFF, rd);
      rchk(`RS_OFF_CAUSE, 32'h01);
      $display("test power_up done");
      for (int k = 1; k >= 0; k--)
      begin
         bus(1'h1, `RS_OFF_CONFIG, {31'h0, k[0]}, rd);
         watchdog_overflow <= 1'h1;
         @(posedge hclk);
         watchdog_overflow <= 1'h0;
         repeat (6) @(posedge hclk);
         `CHK(internal_reset, !k[0])
         wait_run();
      end
      rchk(`RS_OFF_CAUSE, 32'h04);
      `CHK(low_len, 16'h0020)
      $display("test watchdog done");
      ex = 32'h04;
      for (int k = 0; k < 4; k++)
      begin
         ex = exp_cause(ev_tab[k], ex);
         ev(ev_tab[k]);
         `CHK(internal_reset, ev_tab[k] !== 5'h02)
         wait_run();
         rchk(`RS_OFF_CAUSE, ex);
      end
      $display("test cpu_events done");
      for (int k = 0; k < 3; k++)
      begin
         bus(1'h1, `RS_OFF_CONFIG, k * 4, rd);
         brownout_detect <= 1'h1;
         repeat (20) @(posedge hclk);
         `CHK(internal_reset, k == 0)
         brownout_detect <= 1'h0;
         wait_run();
      end
      rchk(`RS_OFF_CAUSE, 32'h20);
      `CHK(low_len >= 16'h1020, 1'h1)
      bus(1'h1, `RS_OFF_CONFIG, 32'h0, rd);
      $display("test brownout done");
      for (int k = 0; k < 2; k++)
      begin
         pull_req <= 1'h1;
         repeat (k ? 100 : 40) @(posedge hclk);
         `CHK(internal_reset, 1'h1)
         pull_req <= 1'h0;
         wait_run();
         rchk(`RS_OFF_CAUSE, k ? 32'h22 : 32'h20);
      end
      power_up_pulse <= 1'h1;
      @(posedge hclk);
      power_up_pulse <= 1'h0;
      wait_run();
      rchk(`RS_OFF_CAUSE, 32'h01);
      $display("test pin_and_power done");
      for (int k = 0; k < 2; k++)
      begin
         bus(1'h1, `RS_OFF_CONFIG, k ? 32'h10 : 32'h12, rd);
         ev(5'h08);
         `CHK({bus_source_clock, internal_bus_clocks, internal_reset}, 3'h0)
         repeat (50) @(posedge hclk);
         ev(5'h01);
         n = 2;
         while (internal_bus_clocks !== 1'h1 && n < 5000)
         begin
            @(posedge hclk);
            n++;
         end
         `CHK(n >= (k ? 4094 : 30) && n <= (k ? 4100 : 36), 1'h1)
      end
      $display("test stop_wake done");
      repeat (6)
      begin
         seed = lfsr(seed);
         int_req <= {seed[7:1], 1'h0} | 8'h80; // bit 0 kept free so the later request outranks
         repeat (2) @(posedge hclk);
         `CHK({int_valid, int_vector}, {1'h1, first_set({seed[7:1], 1'h0} | 8'h80)})
         int_req <= 8'h01;
         int_mask <= seed[8];
         repeat (2) @(posedge hclk);
         `CHK({int_valid, int_vector}, {1'h1, first_set({seed[7:1], 1'h0} | 8'h80)})
         int_service <= 1'h1;
         @(posedge hclk);
         {int_service, int_req, int_mask} <= '0;
         repeat (2) @(posedge hclk);
         `CHK(int_valid, 1'h0)
      end
      $display("test interrupts done");
      give_verdict();
   end
endmodule

`default_nettype wire
